// ### src/mmc_consts.vh
// Constants for the monitor measurement configuration block.
// Assumes a 125 MHz core clock and byte-wide register access.
`ifndef MMC_CONSTS_VH
`define MMC_CONSTS_VH

// Register pointers
`define MMC_PTR_SHUNT_CFG      8'h00
`define MMC_PTR_TEMP_CFG       8'h01

// Reset values
`define MMC_SHUNT_CFG_RST      16'h399f
`define MMC_TEMP_CFG_RST_TRI   16'hff80
`define MMC_TEMP_CFG_RST_DUAL  16'hbf80

// Shunt measurement configuration fields
`define MMC_SOFT_RST_BIT       15
`define MMC_ONE_SHOT_BIT       14
`define MMC_BUS_RANGE_BIT      13
`define MMC_GAIN_HI            12
`define MMC_GAIN_LO            11
`define MMC_BUS_CFG_HI         10
`define MMC_BUS_CFG_LO         7
`define MMC_SHUNT_CFG_HI       6
`define MMC_SHUNT_CFG_LO       3
`define MMC_MODE_HI            2
`define MMC_MODE_LO            0

// Temperature configuration fields
`define MMC_TEMP_CONTINUOUS_BIT_BIT           15
`define MMC_REMOTE_CHAN_EN_3_BIT           14
`define MMC_REMOTE_CHAN_EN_2_BIT           13
`define MMC_REMOTE_CHAN_EN_1_BIT           12
`define MMC_LEN_BIT            11
`define MMC_RES_COMP_BIT       10
`define MMC_RATE_HI            9
`define MMC_RATE_LO            7
`define MMC_PIN_RB_BIT         2
`define MMC_PIN_DRV_HI         1
`define MMC_PIN_DRV_LO         0
`define MMC_TEMP_WR_MASK       16'hff83

// Operating modes
`define MMC_MODE_PDOWN         3'h0
`define MMC_MODE_OFF           3'h4

// Conversion times in microseconds
`define MMC_T9_US              17'h00069
`define MMC_T10_US             17'h000b9
`define MMC_T11_US             17'h00159
`define MMC_T12_US             17'h00299
`define MMC_TAV2_US            17'h00514
`define MMC_TAV4_US            17'h00a14
`define MMC_TAV8_US            17'h0140a
`define MMC_TAV16_US           17'h0280a
`define MMC_TAV32_US           17'h0500a
`define MMC_TAV64_US           17'h0a00a
`define MMC_TAV128_US          17'h14000

// Timing
`define MMC_CLK_MHZ            125
`define MMC_TICK_NS            125000000
`define MMC_CLK_NS             8

`endif

// ### src/mmc_top.v
// Configuration registers and conversion sequencing of a system monitor.
// Assumes a two-wire bus front end that delivers register bytes in order.
`timescale 1ns/100ps
`include "mmc_consts.vh"

module mmc_top #(
  parameter TRIPLE_CHAN = 1,
  parameter CYC_PER_US  = `MMC_CLK_MHZ,
  parameter TICK_CYC    = `MMC_TICK_NS / `MMC_CLK_NS
) (
  // Clock and reset
  input  wire        CLOCK,
  input  wire        RSTN,
  input  wire        CE,
  // Register byte port
  input  wire [7:0]  REG_PTR,
  input  wire        BYTE_LSB,
  input  wire        WR_STB,
  input  wire [7:0]  WR_BYTE,
  input  wire        RD_STB,
  output wire [7:0]  RD_BYTE,
  // Voltage converter control
  output wire        BUS_RANGE_SEL,
  output wire [1:0]  SHUNT_GAIN_SEL,
  output wire [3:0]  BUS_CONVERTER_CFG,
  output wire [3:0]  SHUNT_CONVERTER_CFG,
  output wire        VCONV_BUSY,
  output wire        VCONV_SHUNT_EN,
  output wire        VCONV_BUS_EN,
  output wire        VCONV_DONE,
  // Temperature core control
  output wire [3:0]  TEMP_CHAN_EN,
  output wire        SERIES_RES_COMP_EN,
  output wire        TEMP_ACTIVE,
  output wire        TEMP_PASS_DONE,
  // General-purpose pin
  input  wire        PIN_IN,
  output wire        PIN_OUT,
  output wire        PIN_OE_N
);

  localparam [15:0] TEMP_RST = (TRIPLE_CHAN != 0) ? `MMC_TEMP_CFG_RST_TRI
                                                  : `MMC_TEMP_CFG_RST_DUAL;
  localparam [15:0] TEMP_MASK = (TRIPLE_CHAN != 0) ? `MMC_TEMP_WR_MASK
                                : (`MMC_TEMP_WR_MASK & 16'hbfff);
  localparam [31:0] TICK_LEN = TICK_CYC;
  localparam [31:0] US_LEN   = CYC_PER_US;
  localparam [2:0] V_IDLE = 3'h1;
  localparam [2:0] V_CONV = 3'h2;
  localparam [2:0] V_STOP = 3'h4;
  localparam [2:0] T_OFF  = 3'h1;
  localparam [2:0] T_RUN  = 3'h2;
  localparam [2:0] T_IDLE = 3'h4;

  reg  [15:0] shunt_cfg_ff;
  reg  [15:0] temp_cfg_ff;
  reg  [7:0]  hold_ff;
  reg  [7:0]  rd_byte_ff;
  reg  [2:0]  vstate_ff;
  reg  [31:0] vcnt_ff;
  reg         vdone_ff;
  reg  [2:0]  tstate_ff;
  reg  [31:0] tick_ff;
  reg  [7:0]  per_ff;
  reg         tdone_ff;
  reg         vtrig_ff;
  reg         pin_out_ff;
  reg         pin_oe_n_ff;

  reg  [15:0] nxt_shunt_cfg;
  reg  [15:0] nxt_temp_cfg;
  reg  [2:0]  nxt_vstate;
  reg  [31:0] nxt_vcnt;
  reg  [2:0]  nxt_tstate;
  reg  [7:0]  period;
  reg  [15:0] rd_word;

  // Second byte of a pair commits the whole word
  wire [15:0] wr_word   = {hold_ff, WR_BYTE};
  wire        commit    = WR_STB & BYTE_LSB;
  wire        wr_shunt  = commit & (REG_PTR == `MMC_PTR_SHUNT_CFG);
  wire        wr_temp   = commit & (REG_PTR == `MMC_PTR_TEMP_CFG);
  wire        soft_rst  = wr_shunt & wr_word[`MMC_SOFT_RST_BIT];
  wire        one_shot  = wr_shunt & wr_word[`MMC_ONE_SHOT_BIT] &
                          ~soft_rst;

  // Mode as of this edge's write, so a one-shot sees the new mode
  wire [2:0]  mode      = nxt_shunt_cfg[`MMC_MODE_HI:`MMC_MODE_LO];
  wire        mode_trig = ~mode[2] & (mode != `MMC_MODE_PDOWN);
  wire        mode_temp_continuous_bit = mode[2] & (mode != `MMC_MODE_OFF);
  wire [3:0]  chan      = temp_cfg_ff[`MMC_REMOTE_CHAN_EN_3_BIT:`MMC_LEN_BIT];
  wire [2:0]  nch       = {2'h0, chan[0]} + {2'h0, chan[1]} +
                          {2'h0, chan[2]} + {2'h0, chan[3]};
  wire [2:0]  rate      = temp_cfg_ff[`MMC_RATE_HI:`MMC_RATE_LO];
  wire        temp_continuous_bit      = temp_cfg_ff[`MMC_TEMP_CONTINUOUS_BIT_BIT];
  wire        tick_end  = (tick_ff == TICK_LEN - 32'h1);
  wire        pass_end  = (tstate_ff == T_RUN) & tick_end &
                          (per_ff >= period - 8'h1); // Rate cut mid-pass
  wire        temp_trig = pass_end & (rate != 3'h7) & (nch != 3'h0) &
                          mode_trig;
  wire        vstart    = (mode_temp_continuous_bit | ((one_shot | vtrig_ff) &
                          mode_trig));

  // Conversion time of one converter field in microseconds
  function [16:0] conv_us;
    input [3:0] cfg;
    begin
      if (!cfg[3]) begin
        case (cfg[1:0])
          2'h0:    conv_us = `MMC_T9_US;
          2'h1:    conv_us = `MMC_T10_US;
          2'h2:    conv_us = `MMC_T11_US;
          default: conv_us = `MMC_T12_US;
        endcase
      end else begin
        case (cfg[2:0])
          3'h0:    conv_us = `MMC_T12_US;
          3'h1:    conv_us = `MMC_TAV2_US;
          3'h2:    conv_us = `MMC_TAV4_US;
          3'h3:    conv_us = `MMC_TAV8_US;
          3'h4:    conv_us = `MMC_TAV16_US;
          3'h5:    conv_us = `MMC_TAV32_US;
          3'h6:    conv_us = `MMC_TAV64_US;
          default: conv_us = `MMC_TAV128_US;
        endcase
      end
    end
  endfunction

  // Length taken from the fields being written alongside a one-shot
  wire [16:0] bus_us   = conv_us(nxt_shunt_cfg[`MMC_BUS_CFG_HI:
                                               `MMC_BUS_CFG_LO]);
  wire [16:0] shunt_us = conv_us(nxt_shunt_cfg[`MMC_SHUNT_CFG_HI:
                                               `MMC_SHUNT_CFG_LO]);
  wire [17:0] tot_us   = (mode[0] ? {1'b0, shunt_us} : 18'h0) +
                         (mode[1] ? {1'b0, bus_us} : 18'h0);
  wire [49:0] tot_full = {32'h0, tot_us} * {18'h0, US_LEN};
  wire [31:0] tot_cyc  = tot_full[31:0];

  // Register writes; soft reset overrides everything
  always @* begin
    nxt_shunt_cfg = shunt_cfg_ff;
    nxt_temp_cfg  = temp_cfg_ff;
    if (wr_shunt) begin
      nxt_shunt_cfg = wr_word;
      nxt_shunt_cfg[`MMC_SOFT_RST_BIT] = 1'b0;
      nxt_shunt_cfg[`MMC_ONE_SHOT_BIT] = 1'b0;
    end
    if (wr_temp) begin
      nxt_temp_cfg = wr_word & TEMP_MASK;
    end
    if (soft_rst) begin
      nxt_shunt_cfg = `MMC_SHUNT_CFG_RST;
      nxt_temp_cfg  = TEMP_RST;
    end
  end

  // Voltage converter sequencing
  always @* begin
    nxt_vstate = vstate_ff;
    nxt_vcnt   = vcnt_ff;
    case (vstate_ff)
      V_IDLE: begin
        if (vstart && tot_cyc != 32'h0) begin
          nxt_vstate = V_CONV;
          nxt_vcnt   = tot_cyc;
        end
      end
      V_CONV: begin
        if (mode == `MMC_MODE_PDOWN) begin
          nxt_vstate = V_IDLE;
          nxt_vcnt   = 32'h0;
        end else if (vcnt_ff <= 32'h1) begin
          nxt_vstate = V_STOP;
          nxt_vcnt   = 32'h0;
        end else begin
          nxt_vcnt = vcnt_ff - 32'h1;
        end
      end
      V_STOP: nxt_vstate = V_IDLE;
      default: begin
        nxt_vstate = V_IDLE;
        nxt_vcnt   = 32'h0;
      end
    endcase
  end

  // Temperature pass length in ticks of one eighth second
  always @* begin
    case (rate)
      3'h6:    period = (nch == 3'h4) ? 8'h4 :
                        (nch == 3'h3) ? 8'h3 : 8'h2;
      3'h7:    period = (nch == 3'h4) ? 8'h4 :
                        (nch == 3'h3) ? 8'h3 :
                        (nch == 3'h2) ? 8'h2 : 8'h1;
      default: period = 8'h80 >> rate;
    endcase
  end

  always @* begin
    nxt_tstate = tstate_ff;
    case (tstate_ff)
      T_OFF:   if (temp_continuous_bit || one_shot) nxt_tstate = T_RUN;
      T_RUN:   if (pass_end && !temp_continuous_bit) nxt_tstate = T_IDLE;
      T_IDLE:  if (temp_continuous_bit || one_shot) nxt_tstate = T_RUN;
      default: nxt_tstate = T_OFF;
    endcase
    if (!temp_continuous_bit && nch == 3'h0) nxt_tstate = T_OFF;
  end

  // Read word mux; unmapped pointers read zero
  always @* begin
    case (REG_PTR)
      `MMC_PTR_SHUNT_CFG: rd_word = shunt_cfg_ff;
      `MMC_PTR_TEMP_CFG: begin
        rd_word = temp_cfg_ff;
        rd_word[`MMC_PIN_RB_BIT] = PIN_IN;
      end
      default: rd_word = 16'h0;
    endcase
  end

  always @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      shunt_cfg_ff <= `MMC_SHUNT_CFG_RST;
      temp_cfg_ff  <= TEMP_RST;
      hold_ff      <= 8'h0;
      rd_byte_ff   <= 8'h0;
      vstate_ff    <= V_IDLE;
      vcnt_ff      <= 32'h0;
      vdone_ff     <= 1'b0;
      tstate_ff    <= T_RUN;
      tick_ff      <= 32'h0;
      per_ff       <= 8'h0;
      tdone_ff     <= 1'b0;
      vtrig_ff     <= 1'b0;
      pin_out_ff   <= 1'b0;
      pin_oe_n_ff  <= 1'b1;
    end else if (CE) begin
      shunt_cfg_ff <= nxt_shunt_cfg;
      temp_cfg_ff  <= nxt_temp_cfg;
      if (WR_STB && !BYTE_LSB) hold_ff <= WR_BYTE;
      if (RD_STB) rd_byte_ff <= BYTE_LSB ? rd_word[7:0]
                                         : rd_word[15:8];
      if (soft_rst) begin
        vstate_ff <= V_IDLE;
        vcnt_ff   <= 32'h0;
        vdone_ff  <= 1'b0;
        tstate_ff <= T_RUN;
        tick_ff   <= 32'h0;
        per_ff    <= 8'h0;
        tdone_ff  <= 1'b0;
        vtrig_ff  <= 1'b0;
      end else begin
        vstate_ff <= nxt_vstate;
        vcnt_ff   <= nxt_vcnt;
        vdone_ff  <= (vstate_ff == V_CONV) && (nxt_vstate == V_STOP);
        tstate_ff <= nxt_tstate;
        if (tstate_ff != T_RUN || nxt_tstate != T_RUN || pass_end) begin
          tick_ff <= 32'h0;
          per_ff  <= 8'h0;
        end else if (tick_end) begin
          tick_ff <= 32'h0;
          per_ff  <= per_ff + 8'h1;
        end else begin
          tick_ff <= tick_ff + 32'h1;
        end
        tdone_ff <= pass_end;
        vtrig_ff <= temp_trig;
      end
      pin_out_ff  <= nxt_temp_cfg[`MMC_PIN_DRV_LO];
      pin_oe_n_ff <= ~nxt_temp_cfg[`MMC_PIN_DRV_HI];
    end
  end

  assign RD_BYTE             = rd_byte_ff;
  assign BUS_RANGE_SEL       = shunt_cfg_ff[`MMC_BUS_RANGE_BIT];
  assign SHUNT_GAIN_SEL      = shunt_cfg_ff[`MMC_GAIN_HI:`MMC_GAIN_LO];
  assign BUS_CONVERTER_CFG   = shunt_cfg_ff[`MMC_BUS_CFG_HI:`MMC_BUS_CFG_LO];
  assign SHUNT_CONVERTER_CFG = shunt_cfg_ff[`MMC_SHUNT_CFG_HI:
                                            `MMC_SHUNT_CFG_LO];
  assign VCONV_BUSY          = vstate_ff[1];
  assign VCONV_SHUNT_EN      = shunt_cfg_ff[`MMC_MODE_LO];
  assign VCONV_BUS_EN        = shunt_cfg_ff[`MMC_MODE_LO + 1];
  assign VCONV_DONE          = vdone_ff;
  assign TEMP_CHAN_EN        = temp_cfg_ff[`MMC_REMOTE_CHAN_EN_3_BIT:`MMC_LEN_BIT];
  assign SERIES_RES_COMP_EN  = temp_cfg_ff[`MMC_RES_COMP_BIT];
  assign TEMP_ACTIVE         = tstate_ff[1];
  assign TEMP_PASS_DONE      = tdone_ff;
  assign PIN_OUT             = pin_out_ff;
  assign PIN_OE_N            = pin_oe_n_ff;

endmodule

// ### src/mmc_dummy_guard.v
// Holds no logic; the whole block lives in mmc_top.
// Assumes nothing of its surroundings.
`timescale 1ns/100ps

// ### bench/mmc_properties.sv
// Port checker for the configuration block.
// Assumes one clock domain; bound to every mmc_top instance.
`timescale 1ns/100ps
module mmc_properties (
  // Clock and reset
  input wire       CLOCK,
  input wire       RSTN,
  input wire       CE,
  // Byte port
  input wire [7:0] REG_PTR,
  input wire       BYTE_LSB,
  input wire       RD_STB,
  input wire [7:0] RD_BYTE,
  // Converter side
  input wire       BUS_RANGE_SEL,
  input wire [1:0] SHUNT_GAIN_SEL,
  input wire [3:0] BUS_CONVERTER_CFG,
  input wire [3:0] SHUNT_CONVERTER_CFG,
  input wire       VCONV_BUSY,
  input wire       VCONV_DONE,
  // Temperature side and pin
  input wire [3:0] TEMP_CHAN_EN,
  input wire       SERIES_RES_COMP_EN,
  input wire       TEMP_PASS_DONE,
  input wire       PIN_IN,
  input wire       PIN_OUT,
  input wire       PIN_OE_N
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  sequence s_rd(p, l);
    CE && RD_STB && REG_PTR == p && BYTE_LSB == l;
  endsequence
  chk_shunt_hi_byte: assert property (s_rd(0, 0) |=>
    RD_BYTE == {2'b00, $past(BUS_RANGE_SEL), $past(SHUNT_GAIN_SEL),
    $past(BUS_CONVERTER_CFG[3:1])}) else $error("shunt high byte");
  chk_shunt_lo_byte: assert property (s_rd(0, 1) |=>
    RD_BYTE[7:3] == {$past(BUS_CONVERTER_CFG[0]),
    $past(SHUNT_CONVERTER_CFG)}) else $error("shunt low byte");
  chk_temp_hi_byte: assert property (s_rd(1, 0) |=>
    RD_BYTE[6:2] == {$past(TEMP_CHAN_EN), $past(SERIES_RES_COMP_EN)})
    else $error("temp high byte");
  chk_temp_lo_byte: assert property (s_rd(1, 1) |=>
    RD_BYTE[6:0] == {4'h0, $past(PIN_IN), !$past(PIN_OE_N), $past(PIN_OUT)})
    else $error("temp low byte");
  chk_unmapped_zero: assert property (
    CE && RD_STB && REG_PTR > 8'h01 |=> RD_BYTE == 8'h00)
    else $error("unmapped");
  chk_done_at_end: assert property (
    $rose(VCONV_DONE) |-> $fell(VCONV_BUSY))
    else $error("done without end");
  chk_done_pulse: assert property (
    VCONV_DONE && CE |=> !VCONV_DONE) else $error("done too long");
  chk_pass_pulse: assert property (
    TEMP_PASS_DONE && CE |=> !TEMP_PASS_DONE)
    else $error("pass done too long");
endmodule
bind mmc_top mmc_properties u_chk (.CLOCK(CLOCK), .RSTN(RSTN), .CE(CE),
  .REG_PTR(REG_PTR), .BYTE_LSB(BYTE_LSB), .RD_STB(RD_STB),
  .RD_BYTE(RD_BYTE), .BUS_RANGE_SEL(BUS_RANGE_SEL),
  .SHUNT_GAIN_SEL(SHUNT_GAIN_SEL), .BUS_CONVERTER_CFG(BUS_CONVERTER_CFG),
  .SHUNT_CONVERTER_CFG(SHUNT_CONVERTER_CFG), .VCONV_BUSY(VCONV_BUSY),
  .VCONV_DONE(VCONV_DONE), .TEMP_CHAN_EN(TEMP_CHAN_EN),
  .SERIES_RES_COMP_EN(SERIES_RES_COMP_EN), .TEMP_PASS_DONE(TEMP_PASS_DONE),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N));

// ### bench/mmc_host.sv
// Host model driving the register byte port.
// Assumes the bench calls its tasks; drives on falling clock.
`timescale 1ns/100ps
module mmc_host (
  // Clock
  input  wire       clk,
  // Byte port
  output reg  [7:0] ptr,
  output reg        lsb,
  output reg        wr,
  output reg  [7:0] wdat,
  output reg        rd,
  input  wire [7:0] rdat
);
  initial {ptr, lsb, wr, wdat, rd} = 19'h0;
  // Word goes high byte then low byte
  task wrw(input [7:0] p, input [15:0] d);
    begin
      @(negedge clk) {ptr, lsb, wr, wdat} = {p, 2'b01, d[15:8]};
      @(negedge clk) {lsb, wdat} = {1'b1, d[7:0]};
      @(negedge clk) {wr, wdat} = {1'b0, ~d[7:0]};
      @(negedge clk);
    end
  endtask
  task rdw(input [7:0] p, output [15:0] d);
    begin
      @(negedge clk) {ptr, lsb, rd} = {p, 2'b01};
      @(negedge clk) d[15:8] = rdat;
      lsb = 1'b1;
      @(negedge clk) d[7:0] = rdat;
      rd = 1'b0;
    end
  endtask
endmodule

// ### bench/mmc_top_tb.sv
// Self-checking bench for the configuration block.
// Assumes host model and checker are compiled before it.
`timescale 1ns/100ps
`define CHK(l, e, a) begin num_checks++; if ((a) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", l, e, a); end end
module mmc_top_tb;
  logic        clk = 1'b0, rstn = 1'b0, pin_in = 1'b1, ce = 1'b1;
  int          failures = 0, num_checks = 0, cyc = 0, n;
  logic [15:0] d;
  wire  [7:0]  ptr, wdat, rdat;
  wire  [3:0]  bcfg, scfg, chan;
  wire  [1:0]  gain;
  wire         lsb, wr, rd, range, busy, s_en, b_en, done, act, pdone;
  wire         pout, poe_n, rcomp;
  mmc_top #(.TRIPLE_CHAN(1), .CYC_PER_US(1), .TICK_CYC(4)) dut (
    .CLOCK(clk), .RSTN(rstn), .CE(ce), .REG_PTR(ptr), .BYTE_LSB(lsb),
    .WR_STB(wr), .WR_BYTE(wdat), .RD_STB(rd), .RD_BYTE(rdat),
    .BUS_RANGE_SEL(range), .SHUNT_GAIN_SEL(gain), .BUS_CONVERTER_CFG(bcfg),
    .SHUNT_CONVERTER_CFG(scfg), .VCONV_BUSY(busy), .VCONV_SHUNT_EN(s_en),
    .VCONV_BUS_EN(b_en), .VCONV_DONE(done), .TEMP_CHAN_EN(chan),
    .SERIES_RES_COMP_EN(rcomp), .TEMP_ACTIVE(act), .TEMP_PASS_DONE(pdone),
    .PIN_IN(pin_in), .PIN_OUT(pout), .PIN_OE_N(poe_n));
  mmc_host host (.clk(clk), .ptr(ptr), .lsb(lsb), .wr(wr), .wdat(wdat),
    .rd(rd), .rdat(rdat));
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      conclude;
    end
  end
  task conclude;
    begin
      if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task wait_idle(output int k);
    for (k = 0; busy !== 1'b0 && k < 3000; k++) @(posedge clk) #1;
  endtask
  // Counts cycles with done (0), busy (1) or pass done (2) high
  task count(input int c, input int w, output int k);
    logic s;
    begin
      k = 0;
      repeat (c) begin
        @(posedge clk) #1 s = w == 0 ? done : w == 1 ? busy : pdone;
        // Unknown counts heavily so that no expected count can match
        k += s === 1'b1 ? 1 : s === 1'b0 ? 0 : 1000;
      end
    end
  endtask
  task period(output int k);
    begin
      for (k = 0; pdone !== 1'b1 && k < 600; k++) @(posedge clk) #1;
      k = 0;
      do @(posedge clk) #1 k++; while (pdone !== 1'b1 && k < 600);
    end
  endtask
  task t_defaults;
    begin
      `CHK("fields", 11'h733, {range, gain, bcfg, scfg})
      host.rdw(8'h00, d);
      `CHK("shunt", 16'h399f, d)
      host.rdw(8'h01, d);
      `CHK("temp", 16'hff84, d)
      host.rdw(8'h05, d);
      `CHK("unmapped", 16'h0000, d)
    end
  endtask
  task t_regs;
    begin
      pin_in = 1'b0;
      host.wrw(8'h01, 16'h4ffb);
      host.rdw(8'h01, d);
      `CHK("temp", 16'h4f83, d)
      `CHK("chan", 5'h13, {chan, rcomp})
      for (int c = 0; c < 4; c++) begin
        host.wrw(8'h01, 16'(c));
        `CHK("oe", ~c[1], poe_n)
        if (c > 1) `CHK("out", c[0], pout)
      end
      `CHK("shutdown", 1'b0, act)
      host.wrw(8'h00, 16'h1499);
      `CHK("fields", 11'h293, {range, gain, bcfg, scfg})
      `CHK("mode", 2'b01, {b_en, s_en})
      wait_idle(n);
    end
  endtask
  task t_table;
    logic [15:0] w [10] = '{16'h6001, 16'h6009, 16'h6011, 16'h6019,
      16'h6021, 16'h6041, 16'h6049, 16'h6051, 16'h6482, 16'h6483};
    int t [10] = '{105, 185, 345, 665, 105, 665, 1300, 2580, 1300, 1405};
    for (int i = 0; i < 10; i++) begin
      host.wrw(8'h00, w[i]);
      wait_idle(n);
      `CHK("conv", 1'b1, n >= t[i] - 2 && n <= t[i])
      `CHK("done", 1'b1, done)
    end
  endtask
  task t_modes;
    begin
      host.rdw(8'h00, d);
      `CHK("oneshot", 16'h2483, d)
      host.wrw(8'h00, 16'h6049);
      host.wrw(8'h00, 16'h0000);
      count(4, 0, n);
      `CHK("abort", 0, n + busy)
      host.wrw(8'h00, 16'h4029);
      host.wrw(8'h00, 16'h0024);
      wait_idle(n);
      `CHK("finish", 1'b1, n > 100 && done === 1'b1)
      count(200, 1, n);
      `CHK("halted", 0, n)
    end
  endtask
  task t_temp;
    logic [15:0] w [3] = '{16'h8a80, 16'hbb80, 16'hfb00};
    int p [3] = '{16, 12, 16};
    begin
      host.wrw(8'h01, 16'h0b80);
      count(30, 2, n);
      host.wrw(8'h00, 16'h4004);
      count(60, 2, n);
      `CHK("one pass", 1, n)
      `CHK("idle", 1'b0, act)
      for (int i = 0; i < 3; i++) begin
        host.wrw(8'h01, w[i]);
        period(n);
        period(n);
        `CHK("period", p[i], n)
      end
      host.wrw(8'h00, 16'h0001);
      host.wrw(8'h01, 16'h8b00);
      count(20, 1, n);
      `CHK("trigger", 1'b1, n > 0)
      host.wrw(8'h01, 16'h8b80);
      wait_idle(n);
      count(40, 1, n);
      `CHK("no trigger", 0, n)
      host.wrw(8'h00, 16'h8000);
      host.rdw(8'h00, d);
      `CHK("soft reset", 16'h399f, d)
      host.rdw(8'h01, d);
      `CHK("soft reset", 16'hff80, d)
    end
  endtask
  // Clock enable low: conversion and registers hold, writes are lost
  task t_freeze;
    begin
      @(negedge clk) ce = 1'b0;
      host.wrw(8'h00, 16'h0000);
      count(20, 1, n);
      `CHK("frozen busy", 20, n)
      `CHK("frozen cfg", 11'h733, {range, gain, bcfg, scfg})
      @(negedge clk) ce = 1'b1;
      host.rdw(8'h00, d);
      `CHK("write dropped", 16'h399f, d)
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    t_defaults;
    t_regs;
    t_table;
    t_modes;
    t_temp;
    t_freeze;
    conclude;
  end
endmodule
